// File: design/secl_regs.svh
// Summary of operation
// - enable opcode sets, disable opcode clears the latch at seventh clock rise
// - memory write with the latch clear is discarded, array untouched
// - an executed write clears the latch; each write needs a new enable
// - after reset the latch is clear, writes disabled
// - read: opcode then 16 address bits, 12 to 15 of them used
// - read data driven from falling edge after clock 24, msb first
// - continued clocking streams next addresses, wrapping top to zero
// - write starts on select rise after data; program cycle at most 5 ms
// - during program cycle only status read is accepted
// - select must rise after last data bit, before next rise, else cancelled
// - consecutive data bytes all go into one program cycle, page up to 64
// - page write increments only low address bits, page address fixed
// - more bytes than a page wrap to page start and overwrite older ones
// - status write changes only bits 7, 3 and 2
// - status write programs if select rises between bit0 and next rise
// - block-protected region rejects writes
// - protect pin low from status opcode to select rise cancels status write
// - pause pin low while clock low pauses; clock, data ignored, output off
// - pause pin high while clock low resumes at the same bit
// - select rising while paused resets command state, no resume
// - reads and status reads abort whenever select rises
// - write cancelled by select rise in opcode, address or bits D7..D1
// - status write cancelled before 16th or after 17th rise
// - opcodes: 06 enable, 04 disable, 03 read, 02 write, 05/01 status
`ifndef SECL_REGS_SVH
`define SECL_REGS_SVH

`define SECL_OP_ENABLE      8'h06
`define SECL_OP_DISABLE     8'h04
`define SECL_OP_READ        8'h03
`define SECL_OP_WRITE       8'h02
`define SECL_OP_STAT_RD     8'h05
`define SECL_OP_STAT_WR     8'h01

`define SECL_ST_PPE_BIT     7
`define SECL_ST_BPH_BIT     3
`define SECL_ST_BPL_BIT     2
`define SECL_ST_WEL_BIT     1
`define SECL_ST_BUSY_BIT    0

`define SECL_RST_PPE        1'b0
`define SECL_RST_BP         2'h0

`define SECL_OPC_RISES      16'h0008
`define SECL_ENA_RISES      16'h0007
`define SECL_ADDR_DONE      16'h0018
`define SECL_STAT_DONE      16'h0010

`define SECL_CLK_PERIOD_NS  5
`define SECL_PROG_TIME_NS   5000000
`define SECL_PROG_CYCLES    (`SECL_PROG_TIME_NS / `SECL_CLK_PERIOD_NS)

`endif

// File: design/secl_pkg.sv
package secl_pkg;

  typedef enum logic [2:0] {
    CMD_IDLE   = 3'b000,
    CMD_READ   = 3'b001,
    CMD_WRITE  = 3'b010,
    CMD_STATRD = 3'b011,
    CMD_STATWR = 3'b100,
    CMD_IGNORE = 3'b101
  } secl_cmd_t;

endpackage

// File: design/secl_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module secl_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH)) && !flush;
  assign outValid = (count_r != '0) && !flush;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      store[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outData <= '0;
    end else if (pop) begin
      // popped word shows the cycle after the pop; the reader waits one cycle
      outData <= store[rdPtr_r];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + AW'(1);
      if (pop) rdPtr_r <= rdPtr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// File: design/secl_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "secl_regs.svh"

module secl_core #(
  parameter int ADDR_W      = 15,
  parameter int PAGE_W      = 6,
  parameter int FIFO_DEPTH  = 32,
  parameter int PROG_CYCLES = `SECL_PROG_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic        chipSelectLow_n,
  input  wire logic        transferPausePin_n,
  input  wire logic        writeProtectPin_n,
  output logic             so,
  output logic             soOe,
  output logic             busy,
  output logic             writeEnableLatch,
  output logic [7:0]       statusReg,
  output logic             pageOverrun
);
  localparam int PW = (PAGE_W + 8 > 14) ? PAGE_W + 8 : 14;
  localparam int CW = $clog2(PROG_CYCLES + 1);

  initial begin
    if (ADDR_W < 12 || ADDR_W > 15) $error("address width must be 12 to 15");
    if (PAGE_W < 5 || PAGE_W > 6) $error("page width must be 5 or 6");
    if (PROG_CYCLES < 1) $error("program cycle count must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic [4:0] pinRaw;
  logic [4:0] syncA_r;
  logic [4:0] syncB_r;
  logic       sckD_r;
  logic       csD_r;

  assign pinRaw = {writeProtectPin_n, transferPausePin_n, chipSelectLow_n, si, sck};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gSync
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          // select, pause and protect idle high: no false edge after reset
          syncA_r[g] <= (g >= 2) ? 1'b1 : 1'b0;
          syncB_r[g] <= (g >= 2) ? 1'b1 : 1'b0;
        end else begin
          syncA_r[g] <= pinRaw[g];
          syncB_r[g] <= syncA_r[g];
        end
      end
    end
  endgenerate

  logic sckS;
  logic siS;
  logic csS;
  logic holdS;
  logic wpS;

  assign sckS  = syncB_r[0];
  assign siS   = syncB_r[1];
  assign csS   = syncB_r[2];
  assign holdS = syncB_r[3];
  assign wpS   = syncB_r[4];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sckD_r <= 1'b0;
      csD_r  <= 1'b1;
    end else begin
      sckD_r <= sckS;
      csD_r  <= csS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pause: set and released only while the serial clock is low; select high clears it

  logic pause_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pause_r <= 1'b0;
    end else if (csS) begin
      pause_r <= 1'b0;
    end else if (!sckS) begin
      pause_r <= !holdS;
    end
  end

  logic selected;
  logic sckRise;
  logic sckFall;
  logic csRise;

  // paused edges are simply not seen, so the bit count stays put
  assign selected = !csS && !pause_r;
  assign sckRise  = selected && sckS && !sckD_r;
  assign sckFall  = selected && !sckS && sckD_r;
  assign csRise   = csS && !csD_r;

  ////////////////////////////////////////////////////////////////////////////////
  // receive shifter, bit count and command decode

  logic [15:0]              cnt_r;
  logic [15:0]              cntNxt;
  logic [6:0]               shIn_r;
  logic [7:0]               newByte;
  logic [15:0]              addrSh_r;
  logic                     byteDone_r;
  logic [7:0]               statIn_r;
  logic                     wpCancel_r;
  secl_pkg::secl_cmd_t      cmd_r;
  logic                     wel_r;
  logic                     ppe_r;
  logic [1:0]               bp_r;
  logic [CW-1:0]            progCnt_r;
  logic                     startWrite;
  logic                     startStat;

  assign cntNxt  = (cnt_r == 16'hFFFF) ? cnt_r : cnt_r + 16'h0001;
  assign newByte = {shIn_r, siS};
  assign busy    = (progCnt_r != '0);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r      <= 16'h0000;
      shIn_r     <= 7'h00;
      addrSh_r   <= 16'h0000;
      byteDone_r <= 1'b0;
      statIn_r   <= 8'h00;
      cmd_r      <= secl_pkg::CMD_IDLE;
    end else if (csS) begin
      cnt_r      <= 16'h0000;
      byteDone_r <= 1'b0;
      cmd_r      <= secl_pkg::CMD_IDLE;
    end else if (sckRise) begin
      cnt_r      <= cntNxt;
      shIn_r     <= newByte[6:0];
      byteDone_r <= 1'b0;
      if (cntNxt == `SECL_OPC_RISES) begin
        if (busy && newByte != `SECL_OP_STAT_RD) begin
          cmd_r <= secl_pkg::CMD_IGNORE;
        end else begin
          unique case (newByte)
            `SECL_OP_READ:    cmd_r <= secl_pkg::CMD_READ;
            `SECL_OP_WRITE:   cmd_r <= secl_pkg::CMD_WRITE;
            `SECL_OP_STAT_RD: cmd_r <= secl_pkg::CMD_STATRD;
            `SECL_OP_STAT_WR: cmd_r <= secl_pkg::CMD_STATWR;
            default:          cmd_r <= secl_pkg::CMD_IGNORE;
          endcase
        end
      end
      if (cntNxt > `SECL_OPC_RISES && cntNxt <= `SECL_ADDR_DONE) begin
        addrSh_r <= {addrSh_r[14:0], siS};
      end
      if (cmd_r == secl_pkg::CMD_STATWR && cntNxt == `SECL_STAT_DONE) begin
        statIn_r   <= newByte;
        byteDone_r <= 1'b1;
      end
      if (cmd_r == secl_pkg::CMD_WRITE && cntNxt > `SECL_ADDR_DONE && cntNxt[2:0] == 3'h0) begin
        byteDone_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protect pin watch during a status write

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wpCancel_r <= 1'b0;
    end else if (csS) begin
      wpCancel_r <= 1'b0;
    end else if (cmd_r == secl_pkg::CMD_STATWR && !wpS) begin
      wpCancel_r <= 1'b1;
    end
  end

  // select rise only counts in the one gap after the last bit
  assign startWrite = csRise && !pause_r && wel_r && byteDone_r
                      && cmd_r == secl_pkg::CMD_WRITE;
  assign startStat  = csRise && !pause_r && wel_r && byteDone_r && wpS && !wpCancel_r
                      && cmd_r == secl_pkg::CMD_STATWR;

  ////////////////////////////////////////////////////////////////////////////////
  // write enable latch and status bits

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wel_r <= 1'b0;
    end else if (startWrite || startStat) begin
      wel_r <= 1'b0;
    end else if (sckRise && cntNxt == `SECL_ENA_RISES && !busy) begin
      if (newByte[6:0] == `SECL_OP_ENABLE >> 1) begin
        wel_r <= 1'b1;
      end else if (newByte[6:0] == `SECL_OP_DISABLE >> 1) begin
        wel_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ppe_r <= `SECL_RST_PPE;
      bp_r  <= `SECL_RST_BP;
    end else if (startStat) begin
      ppe_r <= statIn_r[`SECL_ST_PPE_BIT];
      bp_r  <= {statIn_r[`SECL_ST_BPH_BIT], statIn_r[`SECL_ST_BPL_BIT]};
    end
  end

  always_comb begin
    statusReg = 8'h00;
    statusReg[`SECL_ST_PPE_BIT]  = ppe_r;
    statusReg[`SECL_ST_BPH_BIT]  = bp_r[1];
    statusReg[`SECL_ST_BPL_BIT]  = bp_r[0];
    statusReg[`SECL_ST_WEL_BIT]  = wel_r;
    statusReg[`SECL_ST_BUSY_BIT] = busy;
  end

  assign writeEnableLatch = wel_r;

  // nothing stops the timer once started
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      progCnt_r <= '0;
    end else if (startWrite || startStat) begin
      progCnt_r <= CW'(PROG_CYCLES);
    end else if (busy) begin
      progCnt_r <= progCnt_r - CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // page collection through the fifo

  logic [PAGE_W-1:0]        pageIdx_r;
  logic [ADDR_W-PAGE_W-1:0] pageBase_r;
  logic                     fifoInReady;
  logic                     fifoOutValid;
  logic                     fifoOutReady;
  logic [PW-1:0]            fifoOut;
  logic                     pushByte;
  logic                     flushPage;
  logic [7:0]               pageData [1 << PAGE_W];
  logic [(1<<PAGE_W)-1:0]   pageValid_r;
  logic                     commitPend_r;
  logic                     commitRun_r;
  logic [PAGE_W:0]          commitIdx_r;

  assign flushPage    = sckRise && cntNxt == `SECL_OPC_RISES && newByte == `SECL_OP_WRITE
                        && !busy;
  assign pushByte     = sckRise && cmd_r == secl_pkg::CMD_WRITE
                        && cntNxt > `SECL_ADDR_DONE && cntNxt[2:0] == 3'h0;
  assign fifoOutReady = !commitRun_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pageIdx_r   <= '0;
      pageBase_r  <= '0;
      pageOverrun <= 1'b0;
    end else if (flushPage) begin
      pageOverrun <= 1'b0;
    end else if (sckRise && cmd_r == secl_pkg::CMD_WRITE && cntNxt == `SECL_ADDR_DONE) begin
      pageIdx_r  <= {addrSh_r[PAGE_W-2:0], siS};
      pageBase_r <= addrSh_r[ADDR_W-2:PAGE_W-1];
    end else if (pushByte) begin
      pageIdx_r <= pageIdx_r + PAGE_W'(1);
      if (!fifoInReady) pageOverrun <= 1'b1;
    end
  end

  secl_fifo #(
    .WIDTH (PW),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .mclk     (mclk),
    .nrst     (nrst),
    .flush    (flushPage),
    .inValid  (pushByte),
    .inReady  (fifoInReady),
    .inData   (PW'({pageIdx_r, newByte})),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOut)
  );

  // fifo output is registered, so the word is used one cycle after the pop
  logic fifoTake_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fifoTake_r <= 1'b0;
    end else begin
      fifoTake_r <= fifoOutValid && fifoOutReady;
    end
  end

  logic [7:0] popData;
  assign popData = fifoOut[7:0];

  always_ff @(posedge mclk) begin
    if (fifoTake_r) begin
      pageData[fifoOut[PAGE_W+7:8]] <= popData;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pageValid_r <= '0;
    end else if (flushPage) begin
      pageValid_r <= '0;
    end else if (fifoTake_r) begin
      pageValid_r[fifoOut[PAGE_W+7:8]] <= 1'b1;
    end
  end

  // commit waits for the fifo to drain, then walks the whole page once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      commitPend_r <= 1'b0;
      commitRun_r  <= 1'b0;
      commitIdx_r  <= '0;
    end else if (startWrite) begin
      commitPend_r <= 1'b1;
    end else if (commitPend_r && !fifoOutValid && !fifoTake_r) begin
      commitPend_r <= 1'b0;
      commitRun_r  <= 1'b1;
      commitIdx_r  <= '0;
    end else if (commitRun_r) begin
      commitIdx_r <= commitIdx_r + (PAGE_W+1)'(1);
      if (commitIdx_r == (PAGE_W+1)'((1 << PAGE_W) - 1)) commitRun_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array

  logic [7:0]        mem [1 << ADDR_W];
  logic [ADDR_W-1:0] wrAddr;
  logic              wrProt;
  logic [ADDR_W-1:0] rdAddr_r;
  logic [7:0]        memData_r;

  assign wrAddr = {pageBase_r, commitIdx_r[PAGE_W-1:0]};

  always_comb begin
    unique case (bp_r)
      2'h0: wrProt = 1'b0;
      2'h1: wrProt = (wrAddr[ADDR_W-1:ADDR_W-2] == 2'h3);
      2'h2: wrProt = wrAddr[ADDR_W-1];
      2'h3: wrProt = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (commitRun_r && pageValid_r[commitIdx_r[PAGE_W-1:0]] && !wrProt) begin
      mem[wrAddr] <= pageData[commitIdx_r[PAGE_W-1:0]];
    end
    memData_r <= mem[rdAddr_r];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial output

  logic [6:0] txSh_r;
  logic       rdPhase;
  logic       stPhase;

  assign rdPhase = cmd_r == secl_pkg::CMD_READ && cnt_r >= `SECL_ADDR_DONE;
  assign stPhase = cmd_r == secl_pkg::CMD_STATRD && cnt_r >= `SECL_OPC_RISES;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdAddr_r <= '0;
      txSh_r   <= 7'h00;
      so       <= 1'b0;
    end else if (sckRise && cmd_r == secl_pkg::CMD_READ && cntNxt == `SECL_ADDR_DONE) begin
      rdAddr_r <= {addrSh_r[ADDR_W-2:0], siS};
    end else if (sckFall && (rdPhase || stPhase)) begin
      if (cnt_r[2:0] == 3'h0) begin
        if (rdPhase) begin
          {so, txSh_r} <= memData_r;
          rdAddr_r     <= rdAddr_r + ADDR_W'(1);
        end else begin
          {so, txSh_r} <= statusReg;
        end
      end else begin
        {so, txSh_r} <= {txSh_r, 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      soOe <= 1'b0;
    end else if (!selected) begin
      // back on at release of pause once the byte has started
      soOe <= !csS && pause_r && !sckS && holdS && (rdPhase || stPhase);
    end else if (sckFall && (rdPhase || stPhase)) begin
      soOe <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: tb/secl_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module secl_core_sva #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       sck,
  input wire logic       si,
  input wire logic       chipSelectLow_n,
  input wire logic       transferPausePin_n,
  input wire logic       writeProtectPin_n,
  input wire logic       so,
  input wire logic       soOe,
  input wire logic       busy,
  input wire logic       writeEnableLatch,
  input wire logic [7:0] statusReg,
  input wire logic       pageOverrun
);
  logic [31:0] busyCnt_r;
  // length of the running program cycle, zero when idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busyCnt_r <= 32'h0;
    end else begin
      busyCnt_r <= busy ? busyCnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking cbMclk @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // pins seen through two flops, so allow a few mclk before judging
  sequence s_idle; chipSelectLow_n [*8]; endsequence
  sequence s_hold; (!transferPausePin_n && !sck) [*8]; endsequence
  property p_resetClear; $rose(nrst) |-> statusReg == 8'h00; endproperty
  property p_weSel; $rose(writeEnableLatch) |-> !chipSelectLow_n && !busy; endproperty
  property p_weClear; $rose(busy) |-> ##[0:16] !writeEnableLatch; endproperty
  property p_noWrite;
    $rose(chipSelectLow_n) && !writeEnableLatch && !busy |=> !busy [*8];
  endproperty
  property p_start; $rose(busy) |-> chipSelectLow_n && $past(chipSelectLow_n, 3); endproperty
  property p_progLen;
    $fell(busy) |-> busyCnt_r >= PROG_CYCLES - 1 && busyCnt_r <= PROG_CYCLES + 1;
  endproperty
  property p_frozen; busy [*8] |-> $stable(statusReg[7:2]); endproperty
  property p_layout;
    statusReg[6:4] == 3'h0 && statusReg[1:0] == {writeEnableLatch, busy};
  endproperty
  property p_holdQuiet; s_hold |-> !soOe; endproperty
  property p_idleQuiet; s_idle |-> !soOe; endproperty
  property p_drive; $rose(soOe) |-> !chipSelectLow_n && transferPausePin_n; endproperty
  a_resetClear: assert property (p_resetClear) else $error("state not clear after reset");
  a_weSel: assert property (p_weSel) else $error("latch set outside a frame");
  a_weClear: assert property (p_weClear) else $error("latch kept after write");
  a_noWrite: assert property (p_noWrite) else $error("write with latch clear");
  a_start: assert property (p_start) else $error("program before select rise");
  a_progLen: assert property (p_progLen) else $error("program cycle length");
  a_frozen: assert property (p_frozen) else $error("status moved while busy");
  a_layout: assert property (p_layout) else $error("status layout");
  a_holdQuiet: assert property (p_holdQuiet) else $error("output driven in pause");
  a_idleQuiet: assert property (p_idleQuiet) else $error("output driven deselected");
  a_drive: assert property (p_drive) else $error("output enabled out of frame");
endmodule
`default_nettype wire

// File: tb/secl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module secl_host_model (
  input  wire logic mclk,
  input  wire logic so,
  output var logic  sck,
  output var logic  si,
  output var logic  chipSelectLow_n,
  output var logic  transferPausePin_n,
  output var logic  writeProtectPin_n
);
  // mode 0: sck idles low and stands still between frames
  initial begin
    sck = 1'b0;
    si = 1'b0;
    chipSelectLow_n = 1'b1;
    transferPausePin_n = 1'b1;
    writeProtectPin_n = 1'b1;
  end
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask
  task automatic sel();
    chipSelectLow_n = 1'b0;
    half();
  endtask
  // released line shows the inverse so a stale bit never passes for data
  task automatic desel();
    chipSelectLow_n = 1'b1;
    si = ~si;
    half();
  endtask
  task automatic bits(input logic [7:0] v, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      si = v[7 - i];
      half();
      r = {r[6:0], so};
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
  endtask
  // pins move only in the middle of a low sck phase
  task automatic pins(input logic p, input logic w);
    half();
    transferPausePin_n = p;
    writeProtectPin_n = w;
    half();
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PROG = 600;
  localparam int LIMIT = 80000;
  logic        mclk;
  logic        nrst;
  wire logic   sck, si, csN, pauseN, wpN, so, soOe, busy, wel, ovr;
  wire logic [7:0] statusReg;
  logic [7:0]  r;
  logic [7:0]  r1;
  logic [7:0]  ex [3];
  logic [15:0] ad [3] = '{16'h6000, 16'h4000, 16'h2000};
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  secl_core #(.PROG_CYCLES(PROG)) secl_core_inst (.mclk(mclk), .nrst(nrst), .sck(sck), .si(si),
    .chipSelectLow_n(csN), .transferPausePin_n(pauseN), .writeProtectPin_n(wpN), .so(so),
    .soOe(soOe), .busy(busy), .writeEnableLatch(wel), .statusReg(statusReg), .pageOverrun(ovr));
  secl_host_model host (.mclk(mclk), .so(so), .sck(sck), .si(si), .chipSelectLow_n(csN),
    .transferPausePin_n(pauseN), .writeProtectPin_n(wpN));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    host.sel();
    host.bits(c, 8, r);
  endtask
  task automatic part(input logic [7:0] c, input int k);
    host.sel();
    host.bits(c, k, r);
    host.desel();
  endtask
  task automatic addr(input logic [7:0] c, input logic [15:0] a);
    op(c);
    host.bits(a[15:8], 8, r);
    host.bits(a[7:0], 8, r);
  endtask
  task automatic waitIdle();
    repeat (16) @(negedge mclk);
    for (int i = 0; i < 4 * PROG && busy; i++) begin
      @(negedge mclk);
    end
    chk({7'h0, busy}, 8'h00);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic e);
    if (e) begin
      part(8'h06, 8);
    end
    addr(8'h02, a);
    host.bits(d, 8, r);
    host.desel();
    waitIdle();
  endtask
  task automatic nxt(input logic [7:0] e);
    host.bits(8'hFF, 8, r);
    chk(r, e);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    addr(8'h03, a);
    nxt(e);
    host.desel();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    nrst = 1'b0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    chk(statusReg, 8'h00);
    part(8'h06, 6);
    chk(statusReg, 8'h00);
    part(8'h06, 7);
    chk(statusReg, 8'h02);
    part(8'h04, 7);
    chk(statusReg, 8'h00);
    $display("latch test done");
    wr(16'h0000, 8'h5A, 1'b1);
    chk(statusReg, 8'h00);
    wr(16'h0000, 8'hA5, 1'b0);
    rd(16'h0000, 8'h5A);
    part(8'h06, 8);
    addr(8'h02, 16'h0001);
    host.bits(8'h77, 8, r);
    host.desel();
    part(8'h06, 8);
    chk(statusReg, 8'h01);
    op(8'h05);
    nxt(8'h01);
    host.desel();
    waitIdle();
    $display("write test done");
    part(8'h06, 8);
    addr(8'h02, 16'h7FC1);
    for (int i = 0; i < 66; i++) begin
      host.bits(i[7:0], 8, r);
    end
    host.desel();
    waitIdle();
    chk({7'h0, ovr}, 8'h00);
    addr(8'h03, 16'h7FC0);
    nxt(8'h3F);
    nxt(8'h40);
    nxt(8'h41);
    host.desel();
    addr(8'h03, 16'h7FFF);
    nxt(8'h3E);
    nxt(8'h5A);
    host.desel();
    $display("page test done");
    part(8'h06, 8);
    addr(8'h02, 16'h0000);
    host.bits(8'hEE, 7, r);
    host.desel();
    chk(statusReg, 8'h02);
    addr(8'h02, 16'h0000);
    host.bits(8'hEE, 8, r);
    host.bits(8'hFF, 1, r);
    host.desel();
    chk(statusReg, 8'h02);
    rd(16'h0000, 8'h5A);
    for (int k = 7; k < 10; k += 2) begin
      op(8'h01);
      host.bits(8'hFF, k, r);
      host.desel();
      chk(statusReg, 8'h02);
    end
    host.pins(1'b1, 1'b0);
    op(8'h01);
    host.bits(8'hFF, 8, r);
    host.desel();
    host.pins(1'b1, 1'b1);
    chk(statusReg, 8'h02);
    $display("cancel test done");
    for (int k = 0; k < 4; k++) begin
      part(8'h06, 8);
      op(8'h01);
      host.bits({1'b1, 3'b111, k[1:0], 2'b11}, 8, r);
      host.desel();
      waitIdle();
      chk(statusReg, {1'b1, 3'b000, k[1:0], 2'b00});
      for (int j = 0; j < 3; j++) begin
        wr(ad[j], {k[3:0], j[3:0]}, 1'b1);
        if (k == 0 || (k == 1 && j > 0) || (k == 2 && j == 2)) begin
          ex[j] = {k[3:0], j[3:0]};
        end
      end
      for (int j = 0; j < 3; j++) begin
        rd(ad[j], ex[j]);
      end
    end
    $display("protect test done");
    addr(8'h03, 16'h7FFF);
    host.bits(8'hFF, 3, r1);
    host.pins(1'b0, 1'b1);
    chk({7'h0, soOe}, 8'h00);
    host.bits(8'h00, 2, r);
    host.pins(1'b1, 1'b1);
    host.bits(8'hFF, 5, r);
    chk({r1[2:0], r[4:0]}, 8'h3E);
    nxt(8'h5A);
    host.desel();
    addr(8'h03, 16'h0000);
    host.pins(1'b0, 1'b1);
    host.desel();
    host.pins(1'b1, 1'b1);
    rd(16'h0000, 8'h5A);
    $display("pause test done");
    // unprotect, then a half page through the byte buffer must land in order
    part(8'h06, 8);
    op(8'h01);
    host.bits(8'h00, 8, r);
    host.desel();
    waitIdle();
    chk(statusReg, 8'h00);
    part(8'h06, 8);
    addr(8'h02, 16'h1000);
    for (int j = 0; j < 32; j++) begin
      host.bits(8'hC0 + j[7:0], 8, r);
    end
    host.desel();
    waitIdle();
    chk({7'h0, ovr}, 8'h00);
    addr(8'h03, 16'h1000);
    for (int j = 0; j < 32; j++) begin
      nxt(8'hC0 + j[7:0]);
    end
    host.desel();
    $display("buffer test done");
    print_verdict();
  end
endmodule
bind secl_core secl_core_sva #(.PROG_CYCLES(PROG_CYCLES)) secl_core_sva_inst (.mclk(mclk),
  .nrst(nrst), .sck(sck), .si(si), .chipSelectLow_n(chipSelectLow_n),
  .transferPausePin_n(transferPausePin_n), .writeProtectPin_n(writeProtectPin_n), .so(so),
  .soOe(soOe), .busy(busy), .writeEnableLatch(writeEnableLatch), .statusReg(statusReg),
  .pageOverrun(pageOverrun));
`default_nettype wire
